// ---- memmap_consts.svh ----
// offsets, field positions, reset values and region bounds of the memory map decoder
`ifndef MEMMAP_CONSTS_SVH
`define MEMMAP_CONSTS_SVH

`define PC_WIDTH 13
`define RESET_VECTOR 13'h0000
`define INTR_VECTOR 13'h0004
`define SMALL_PROG_MASK 13'h03ff
`define LARGE_PROG_MASK 13'h07ff

`define OFS_INDIRECT_PORT 7'h00
`define OFS_PC_LOW 7'h02
`define OFS_STATUS 7'h03
`define OFS_POINTER 7'h04
`define OFS_PC_HIGH 7'h0a
`define OFS_INTR_CTRL 7'h0b

`define STATUS_BANK_BIT 5
`define STATUS_UPPER_BANK_BIT 6
`define STATUS_IND_BANK_BIT 7
`define STATUS_RESET 8'h18
`define INTR_CTRL_RESET 8'h00
`define PC_HIGH_RESET 8'h00

`define SFR_TOP 7'h1f
`define SMALL_RAM_LO 7'h40
`define LARGE_RAM_LO 7'h20
`define BANK1_RAM_TOP 7'h6f
`define COMMON_LO 7'h70
`define RAM_WORDS 128
`define UPPER_RAM_WORDS 80

`endif

// ---- memmap_pkg.sv ----
// types shared by the memory map decoder
`default_nettype none
package memmap_pkg;
    typedef enum logic [2:0] {
        REGION_NONE = 3'b000,
        REGION_CORE = 3'b001,
        REGION_PERIPH = 3'b010,
        REGION_RAM = 3'b011
    } region_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } data_req_t;

    typedef struct packed {
        logic [12:0] pc;
        logic [12:0] phys;
    } fetch_t;
endpackage
`default_nettype wire

// ---- banked_memory_map_decoder.sv ----
// program counter, bank decode, core registers and general ram of the small core
//
// What this block does
// - the program counter is 13 bits wide, spanning 8K words of 14 bits.
// - the small variant implements program words 0000h to 03FFh only.
// - the large variant implements program words 0000h to 07FFh.
// - program addresses above the implemented region wrap by dropping upper bits.
// - reset starts execution at 0000h and interrupt entry loads 0004h.
// - data memory has two banks whose lowest 32 locations are special registers.
// - in the small variant bank 0 locations 40h to 7Fh are general ram.
// - in the large variant 20h to 7Fh of bank 0 and A0h to EFh of bank 1 are ram.
// - bank 1 locations F0h to FFh reach the same storage as bank 0 70h to 7Fh.
// - unimplemented data addresses read zero and ignore writes.
// - the bank select bit of the status register picks the bank for direct access.
// - the general ram holds 64 bytes small and 176 bytes large.
// - every data register is reachable directly and through the indirect pointer.
// - special registers are static storage and hold their value with the clock stopped.
`include "memmap_consts.svh"
`default_nettype none
module banked_memory_map_decoder #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // program counter control from the core
    input wire logic i_pc_advance,
    input wire logic i_pc_load,
    input wire logic [12:0] i_pc_load_value,
    input wire logic i_intr_entry,
    // operand access from the core
    input wire logic i_data_valid,
    input wire logic i_data_write,
    input wire logic [6:0] i_data_addr,
    input wire logic [7:0] i_data_wdata,
    // peripheral register read-back for the address of the current request, sampled with it
    input wire logic [7:0] i_periph_rdata,
    // fetch address out
    output logic [12:0] o_pc,
    output logic [12:0] o_fetch_addr,
    // operand answer
    output logic [7:0] o_data_rdata,
    output logic o_data_ack,
    // peripheral strobe
    output logic o_periph_write,
    output logic [7:0] o_periph_addr,
    output logic [7:0] o_periph_wdata,
    // core register view
    output logic [7:0] o_status,
    output logic [7:0] o_pointer,
    output logic [7:0] o_pc_high,
    output logic [7:0] o_intr_ctrl
);

    // the mask is fixed by the variant, so wrap-around costs no logic beyond an and
    localparam logic [12:0] PROG_MASK = LARGE_VARIANT ? `LARGE_PROG_MASK : `SMALL_PROG_MASK;

    logic [12:0] pc;
    logic [7:0] status;
    logic [7:0] pointer;
    logic [7:0] pc_high;
    logic [7:0] intr_ctrl;
    // ram array is static storage like the registers: nothing refreshes it with the clock
    logic [7:0] general_ram [`RAM_WORDS];
    // bank 1 area of the large variant has storage of its own so it never aliases bank 0
    logic [7:0] upper_ram [`UPPER_RAM_WORDS];

    memmap_pkg::data_req_t req;
    logic [7:0] full_addr;
    memmap_pkg::region_t region;
    logic [6:0] ram_index;
    logic in_upper;
    logic core_write;
    logic periph_write;
    logic ram_write;
    logic [7:0] core_rdata;
    logic [7:0] ram_rdata;
    logic [7:0] next_rdata;
    logic [12:0] next_pc;
    logic pc_low_write;

    // bank 1 area a0h..efh sits apart from the rest of the ram
    function automatic logic upper_area(input logic [7:0] a);
        upper_area = a[7] && a[6:0] < `COMMON_LO;
    endfunction

    // ram index: common region folds onto bank 0 slots, bank 1 area counts from its base
    function automatic logic [6:0] ram_slot(input logic [7:0] a);
        if (upper_area(a)) begin
            ram_slot = 7'(a[6:0] - `LARGE_RAM_LO);
        end else begin
            ram_slot = a[6:0];
        end
    endfunction

    // one decode of a qualified write, shared by every storage element
    function automatic logic write_to(
        input memmap_pkg::data_req_t r,
        input memmap_pkg::region_t where,
        input memmap_pkg::region_t want
    );
        write_to = r.valid && r.write && where == want;
    endfunction

    function automatic memmap_pkg::region_t classify(input logic [7:0] a);
        logic [6:0] ofs;
        ofs = a[6:0];
        if (ofs <= `SFR_TOP) begin
            if (ofs == `OFS_INDIRECT_PORT || ofs == `OFS_PC_LOW || ofs == `OFS_STATUS
                || ofs == `OFS_POINTER || ofs == `OFS_PC_HIGH || ofs == `OFS_INTR_CTRL) begin
                classify = memmap_pkg::REGION_CORE;
            end else begin
                classify = memmap_pkg::REGION_PERIPH;
            end
        end else if (ofs >= `COMMON_LO) begin
            classify = memmap_pkg::REGION_RAM;
        end else if (!a[7] && ofs >= `SMALL_RAM_LO) begin
            classify = memmap_pkg::REGION_RAM;
        end else if (LARGE_VARIANT && !a[7] && ofs >= `LARGE_RAM_LO) begin
            classify = memmap_pkg::REGION_RAM;
        end else if (LARGE_VARIANT && a[7] && ofs >= `LARGE_RAM_LO && ofs <= `BANK1_RAM_TOP) begin
            classify = memmap_pkg::REGION_RAM;
        end else begin
            classify = memmap_pkg::REGION_NONE;
        end
    endfunction

    // indirect port reroutes through the pointer, ignoring the bank bit
    always_comb begin
        req.valid = i_data_valid;
        req.write = i_data_write;
        req.wdata = i_data_wdata;
        if (i_data_addr == `OFS_INDIRECT_PORT) begin
            req.addr = pointer;
        end else begin
            req.addr = {status[`STATUS_BANK_BIT], i_data_addr};
        end
    end

    always_comb begin
        full_addr = req.addr;
        region = classify(full_addr);
        // an indirect access that points back at the port itself reaches nothing
        if (i_data_addr == `OFS_INDIRECT_PORT && full_addr[6:0] == `OFS_INDIRECT_PORT) begin
            region = memmap_pkg::REGION_NONE;
        end
        in_upper = upper_area(full_addr);
        ram_index = ram_slot(full_addr);
    end

    // every storage element acts on the same qualified decode
    always_comb begin
        core_write = write_to(req, region, memmap_pkg::REGION_CORE);
        periph_write = write_to(req, region, memmap_pkg::REGION_PERIPH);
        ram_write = write_to(req, region, memmap_pkg::REGION_RAM);
    end

    // core registers read at their own offset in either bank
    always_comb begin
        case (full_addr[6:0])
            `OFS_PC_LOW: core_rdata = pc[7:0];
            `OFS_STATUS: core_rdata = status;
            `OFS_POINTER: core_rdata = pointer;
            `OFS_PC_HIGH: core_rdata = pc_high;
            `OFS_INTR_CTRL: core_rdata = intr_ctrl;
            default: core_rdata = 8'h00;
        endcase
    end

    // the upper area is picked for any bank 1 address below f0h; only the large variant lets it through
    always_comb begin
        if (in_upper) begin
            ram_rdata = upper_ram[ram_index];
        end else begin
            ram_rdata = general_ram[ram_index];
        end
    end

    always_comb begin
        case (region)
            memmap_pkg::REGION_CORE: next_rdata = core_rdata;
            memmap_pkg::REGION_PERIPH: next_rdata = i_periph_rdata;
            memmap_pkg::REGION_RAM: next_rdata = ram_rdata;
            default: next_rdata = 8'h00;
        endcase
    end

    // a write to the low byte jumps, taking the high part from the latch
    assign pc_low_write = core_write && full_addr[6:0] == `OFS_PC_LOW;

    // priority: interrupt entry, then explicit load, then a write to the low byte, then advance
    always_comb begin
        if (i_intr_entry) begin
            next_pc = `INTR_VECTOR;
        end else if (i_pc_load) begin
            next_pc = i_pc_load_value;
        end else if (pc_low_write) begin
            next_pc = {pc_high[4:0], req.wdata};
        end else if (i_pc_advance) begin
            next_pc = 13'(pc + 13'h0001);
        end else begin
            next_pc = pc;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pc <= `RESET_VECTOR;
        end else begin
            pc <= next_pc;
        end
    end

    // the pc view is a flop of its own so the output never waits on decode
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_pc <= `RESET_VECTOR;
        end else begin
            o_pc <= next_pc;
        end
    end

    // only the low bits select the physical word, so a high address wraps into the region
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_fetch_addr <= `RESET_VECTOR;
        end else begin
            o_fetch_addr <= next_pc & PROG_MASK;
        end
    end

    // reserved bank bits are stored as written: the core is trusted to keep them zero
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            status <= `STATUS_RESET;
        end else if (core_write && full_addr[6:0] == `OFS_STATUS) begin
            status <= req.wdata;
        end
    end

    // pointer is a full 8-bit address, so the indirect bank bit is never needed
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pointer <= 8'h00;
        end else if (core_write && full_addr[6:0] == `OFS_POINTER) begin
            pointer <= req.wdata;
        end
    end

    // the latch only reaches the pc through a write to the low byte
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pc_high <= `PC_HIGH_RESET;
        end else if (core_write && full_addr[6:0] == `OFS_PC_HIGH) begin
            pc_high <= req.wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            intr_ctrl <= `INTR_CTRL_RESET;
        end else if (core_write && full_addr[6:0] == `OFS_INTR_CTRL) begin
            intr_ctrl <= req.wdata;
        end
    end

    // no reset on the ram: contents are undefined at power-up as with any static array
    always_ff @(posedge i_clk) begin
        if (ram_write && !in_upper) begin
            general_ram[ram_index] <= req.wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (ram_write && in_upper) begin
            upper_ram[ram_index] <= req.wdata;
        end
    end

    // answer: one cycle after the request, zero when nothing is asked
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_data_ack <= 1'b0;
            o_data_rdata <= 8'h00;
        end else begin
            o_data_ack <= req.valid;
            o_data_rdata <= req.valid ? next_rdata : 8'h00;
        end
    end

    // address and data follow every request; only the strobe says a write happened
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_periph_write <= 1'b0;
            o_periph_addr <= 8'h00;
            o_periph_wdata <= 8'h00;
        end else begin
            o_periph_write <= periph_write;
            o_periph_addr <= full_addr;
            o_periph_wdata <= req.wdata;
        end
    end

    // register views trail the registers by one cycle
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_status <= `STATUS_RESET;
        end else begin
            o_status <= status;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_pointer <= 8'h00;
        end else begin
            o_pointer <= pointer;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_pc_high <= `PC_HIGH_RESET;
        end else begin
            o_pc_high <= pc_high;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_intr_ctrl <= `INTR_CTRL_RESET;
        end else begin
            o_intr_ctrl <= intr_ctrl;
        end
    end

endmodule
`default_nettype wire

// ---- periph_model.sv ----
// stand-in for the peripheral registers behind the decoder
`default_nettype none
module periph_model (
    input wire logic i_bank,
    input wire logic [6:0] i_addr,
    output logic [7:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // answers from the full banked address, since the decoder samples it with the request
    assign o_rdata = {i_bank, i_addr} ^ 8'h5a;
endmodule
`default_nettype wire

// ---- memmap_chk.sv ----
// port assertions for the memory map decoder
`default_nettype none
module memmap_chk #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    // requests
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_intr_entry,
    input wire logic i_data_valid,
    input wire logic i_data_write,
    input wire logic [6:0] i_data_addr,
    input wire logic [7:0] i_data_wdata,
    // answers
    input wire logic [12:0] o_pc,
    input wire logic [12:0] o_fetch_addr,
    input wire logic [7:0] o_data_rdata,
    input wire logic o_data_ack,
    input wire logic o_periph_write,
    input wire logic [7:0] o_periph_addr,
    input wire logic [7:0] o_periph_wdata,
    input wire logic [7:0] o_pointer
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [12:0] MASK = LARGE_VARIANT ? 13'h07ff : 13'h03ff;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    property p_rst; disable iff (1'b0) i_srst |=> o_pc == 13'h0000 && !o_data_ack; endproperty
    a_rst: assert property (p_rst) else $error("pc or ack wrong after reset");
    property p_intr; i_intr_entry |=> o_pc == 13'h0004; endproperty
    a_intr: assert property (p_intr) else $error("interrupt vector missed");
    property p_wrap; o_fetch_addr == (o_pc & MASK); endproperty
    a_wrap: assert property (p_wrap) else $error("fetch address not wrapped");
    property p_ack; i_data_valid |=> o_data_ack; endproperty
    a_ack: assert property (p_ack) else $error("access not answered");
    property p_idle; !i_data_valid |=> !o_data_ack && o_data_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_pwr; i_data_valid && i_data_write && i_data_addr == 7'h05 |=> o_periph_write; endproperty
    a_pwr: assert property (p_pwr) else $error("peripheral write lost");
    property p_gwr; i_data_valid && i_data_write && i_data_addr >= 7'h20 |=> !o_periph_write; endproperty
    a_gwr: assert property (p_gwr) else $error("ram write reached peripheral");
    property p_paddr; i_data_valid && i_data_write && i_data_addr == 7'h05
        |=> o_periph_addr[6:0] == 7'h05 && o_periph_wdata == $past(i_data_wdata); endproperty
    a_paddr: assert property (p_paddr) else $error("peripheral address or data wrong");
    property p_ptr; i_data_valid && i_data_write && i_data_addr == 7'h04
        |=> !o_periph_write ##1 o_pointer == $past(i_data_wdata, 2); endproperty
    a_ptr: assert property (p_ptr) else $error("pointer write lost");
    c_intr: cover property (i_intr_entry);
    c_ind: cover property (i_data_valid && i_data_addr == 7'h00);
    c_pwr: cover property (o_periph_write);
endmodule
`default_nettype wire

// ---- testbench.sv ----
// bench for the memory map decoder, small variant
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, adv = 1'b0, ld = 1'b0, intr = 1'b0, bank = 1'b0;
    logic valid = 1'b0, wr = 1'b0, ack;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00, prd, rdata;
    logic [7:0] stat, phigh, ictl;
    logic [7:0] ram [128];
    logic [12:0] ldv = 13'h0000, pc, fetch, r;
    logic [8:0] n;
    logic [8:0] expq [$];
    int failures = 0, comparisons = 0, cycles = 0;
    banked_memory_map_decoder #(.LARGE_VARIANT(1'b0)) dut (.i_clk(clk), .i_srst(srst),
        .i_pc_advance(adv), .i_pc_load(ld), .i_pc_load_value(ldv), .i_intr_entry(intr),
        .i_data_valid(valid), .i_data_write(wr), .i_data_addr(addr), .i_data_wdata(wdata),
        .i_periph_rdata(prd), .o_pc(pc), .o_fetch_addr(fetch), .o_data_rdata(rdata),
        .o_data_ack(ack), .o_periph_write(), .o_periph_addr(), .o_periph_wdata(),
        .o_status(stat), .o_pointer(), .o_pc_high(phigh), .o_intr_ctrl(ictl));
    periph_model peer (.i_bank(bank), .i_addr(addr), .o_rdata(prd));
    always #12.5 clk = ~clk;
    task automatic check(logic [12:0] seen, logic [12:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one access per cycle; the expectation is queued with it
    task automatic acc(logic w, logic [6:0] a, logic [7:0] d, logic c, logic [7:0] e);
        @(posedge clk);
        valid <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        expq.push_back({c, e});
    endtask
    task automatic check_pc(logic [12:0] e);
        repeat (2) @(posedge clk);
        #1;
        check(pc, e);
        check(fetch, e & 13'h03ff);
    endtask
    task automatic pc_op(logic i, logic [12:0] v, logic [12:0] e);
        @(posedge clk);
        valid <= 1'b0;
        ld <= 1'b1;
        intr <= i;
        ldv <= v;
        @(posedge clk);
        ld <= 1'b0;
        intr <= 1'b0;
        check_pc(e);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            close_out();
        end
        if (ack === 1'b1 && expq.size() > 0) begin
            n = expq.pop_front();
            if (n[8])
                check({5'h00, rdata}, {5'h00, n[7:0]});
        end
    end
    initial begin
        r = 13'($urandom(32'h90d6));
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        check_pc(13'h0000);
        acc(1'b0, 7'h03, 8'h00, 1'b1, 8'h18);
        for (int k = 32; k < 128; k++) begin
            ram[k] = 8'($urandom);
            acc(1'b1, 7'(k), ram[k], 1'b0, 8'h00);
        end
        for (int k = 32; k < 128; k++)
            acc(1'b0, 7'(k), 8'h00, 1'b1, k < 64 ? 8'h00 : ram[k]);
        acc(1'b1, 7'h03, 8'h38, 1'b0, 8'h00);
        bank = 1'b1;
        for (int k = 96; k < 128; k++)
            acc(1'b0, 7'(k), 8'h00, 1'b1, k < 112 ? 8'h00 : ram[k]);
        acc(1'b0, 7'h05, 8'h00, 1'b1, 8'h85 ^ 8'h5a);
        acc(1'b1, 7'h05, 8'h77, 1'b0, 8'h00);
        acc(1'b1, 7'h04, 8'hf5, 1'b0, 8'h00);
        acc(1'b0, 7'h04, 8'h00, 1'b1, 8'hf5);
        acc(1'b0, 7'h00, 8'h00, 1'b1, ram[117]);
        acc(1'b1, 7'h00, 8'h99, 1'b0, 8'h00);
        acc(1'b1, 7'h03, 8'h18, 1'b0, 8'h00);
        bank = 1'b0;
        acc(1'b0, 7'h75, 8'h00, 1'b1, 8'h99);
        acc(1'b1, 7'h0a, 8'h03, 1'b0, 8'h00);
        acc(1'b0, 7'h0a, 8'h00, 1'b1, 8'h03);
        acc(1'b1, 7'h0b, 8'ha5, 1'b0, 8'h00);
        acc(1'b0, 7'h0b, 8'h00, 1'b1, 8'ha5);
        acc(1'b1, 7'h02, 8'h45, 1'b0, 8'h00);
        check_pc(13'h0345);
        $display("test data map done");
        pc_op(1'b0, 13'h1abc, 13'h1abc);
        pc_op(1'b1, 13'h0abc, 13'h0004);
        repeat (4) begin
            r = 13'($urandom);
            pc_op(1'b0, r, r);
        end
        @(posedge clk);
        adv <= 1'b1;
        repeat (3) @(posedge clk);
        adv <= 1'b0;
        check_pc(r + 13'h0003);
        $display("test program map done");
        check(13'(expq.size()), 13'h0000);
        check({5'h00, stat}, 13'h0018);
        check({5'h00, phigh}, 13'h0003);
        check({5'h00, ictl}, 13'h00a5);
        close_out();
    end
endmodule
bind banked_memory_map_decoder memmap_chk #(.LARGE_VARIANT(LARGE_VARIANT)) chk (
    .i_clk(i_clk), .i_srst(i_srst), .i_intr_entry(i_intr_entry),
    .i_data_valid(i_data_valid), .i_data_write(i_data_write), .i_data_addr(i_data_addr),
    .i_data_wdata(i_data_wdata), .o_pc(o_pc), .o_fetch_addr(o_fetch_addr),
    .o_data_rdata(o_data_rdata), .o_data_ack(o_data_ack), .o_periph_write(o_periph_write),
    .o_periph_addr(o_periph_addr), .o_periph_wdata(o_periph_wdata), .o_pointer(o_pointer));
`default_nettype wire
